// ===== src/flash_host_pkg.sv
// Constants for the parallel flash host-side command sequencer
// Function
// RULE1: Commands use fifteen address bits, low byte
// RULE2: Program is four writes, then target word; the sequencer sends three command writes, then the target word
// RULE3: Chip erase is six writes ending 10
// RULE4: Main erase is six writes ending 30
// RULE5: Lockout set ends 40, then wait one second
// RULE6: ID entry three writes, wait 20 us
// RULE7: ID exit three writes, wait 20 us
// RULE8: Device also exits on single F0 write
// RULE9: ID read gives maker or part code
// RULE10: Lockout read gives FF set, FE clear
// RULE11: ID mode lost over power cycle
// RULE12: Device reads array after ID exit
// RULE13: Elevated sense line gives pin-level ID
// RULE14: Device drives data only when selected, gated
// RULE15: Device ignores writes unless strobed properly
// RULE16: Poll bit complemented until operation done
// RULE17: Toggle bit flips each read while busy
// RULE18: Wrong step abandons partial command sequence
// RULE19: Lockout protects boot region from changes
// RULE20: No new commands while operation runs
package flash_host_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
    localparam logic [14:0] UNLOCK_ADDR2 = 15'h2aaa;
    localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_MAIN_ERASE = 8'h30;
    localparam logic [7:0] CMD_LOCKOUT = 8'h40;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int CLK_MHZ = 250;
    localparam int ID_PAUSE_US = 20;
    localparam int LOCKOUT_PAUSE_MS = 1000;
    localparam int ID_PAUSE_CYCLES = ID_PAUSE_US * CLK_MHZ;
    localparam int LOCKOUT_PAUSE_CYCLES = LOCKOUT_PAUSE_MS * 1000 * CLK_MHZ;
    // Bus cycle phase lengths in ns, then in clocks rounded up
    localparam int STROBE_NS = 200;
    localparam int READ_NS = 120;
    localparam int SETUP_NS = 100;
    localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYCLES = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYCLES = (SETUP_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0]
    {
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_MAIN_ERASE,
        OP_LOCKOUT,
        OP_ID_ENTRY,
        OP_ID_EXIT,
        OP_ID_EXIT_SHORT,
        OP_READ
    } op_t;
endpackage

// ===== src/flash_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic is_write,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] wdata,
    output logic done,
    output logic [flash_host_pkg::DATA_W-1:0] rdata,
    output logic [flash_host_pkg::ADDR_W-1:0] address_pins,
    output logic [flash_host_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_pins_in,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cyc_t;
    localparam logic [7:0] SETUP_LEN = 8'(flash_host_pkg::SETUP_CYCLES);
    localparam logic [7:0] STROBE_LEN = 8'(flash_host_pkg::STROBE_CYCLES);
    localparam logic [7:0] READ_LEN = 8'(flash_host_pkg::READ_CYCLES);
    cyc_t state, next_state;
    logic [7:0] cnt, next_cnt;
    logic wr, next_wr;
    logic [flash_host_pkg::ADDR_W-1:0] next_address_pins;
    logic [flash_host_pkg::DATA_W-1:0] next_data_pins_out, next_rdata;
    logic next_oe, next_cs_n, next_og_n, next_ws_n, next_done;

    // ----
    // Cycle sequencing
    // ----
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_wr = wr;
        next_address_pins = address_pins;
        next_data_pins_out = data_pins_out;
        next_rdata = rdata;
        next_oe = data_pins_oe;
        next_cs_n = chip_select_n;
        next_og_n = output_gate_n;
        next_ws_n = write_strobe_n;
        next_done = 1'b0;
        case (state)
            C_IDLE:
            begin
                if (start)
                begin
                    next_wr = is_write;
                    next_address_pins = addr;
                    next_data_pins_out = wdata;
                    // Gate high through writes
                    next_oe = is_write; // RULE15
                    next_cs_n = 1'b0;
                    next_cnt = SETUP_LEN;
                    next_state = C_SETUP;
                end
            end
            C_SETUP:
            begin
                if (cnt == 8'h00)
                begin
                    if (wr)
                        next_ws_n = 1'b0; // RULE15
                    else
                        next_og_n = 1'b0; // RULE14
                    next_cnt = wr ? STROBE_LEN : READ_LEN;
                    next_state = C_STROBE;
                end
                else
                    next_cnt = cnt - 8'h01;
            end
            C_STROBE:
            begin
                if (cnt == 8'h00)
                begin
                    next_rdata = data_pins_in;
                    next_ws_n = 1'b1;
                    next_og_n = 1'b1;
                    next_cnt = SETUP_LEN;
                    next_state = C_HOLD;
                end
                else
                    next_cnt = cnt - 8'h01;
            end
            C_HOLD:
            begin
                // Hold data past strobe edge
                if (cnt == 8'h00)
                begin
                    next_cs_n = 1'b1;
                    next_oe = 1'b0;
                    next_done = 1'b1;
                    next_state = C_IDLE;
                end
                else
                    next_cnt = cnt - 8'h01;
            end
            default:
                next_state = C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= C_IDLE;
            cnt <= 8'h00;
            wr <= 1'b0;
            address_pins <= '0;
            data_pins_out <= '0;
            rdata <= '0;
            data_pins_oe <= 1'b0;
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            wr <= next_wr;
            address_pins <= next_address_pins;
            data_pins_out <= next_data_pins_out;
            rdata <= next_rdata;
            data_pins_oe <= next_oe;
            chip_select_n <= next_cs_n;
            output_gate_n <= next_og_n;
            write_strobe_n <= next_ws_n;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// ===== src/flash_command_host.sv
// Host-side sequencer that issues flash command sequences and polls completion
`timescale 1ns/100ps
`default_nettype none
module flash_command_host
#(
    parameter int ID_PAUSE = flash_host_pkg::ID_PAUSE_CYCLES,
    parameter int LOCKOUT_PAUSE = flash_host_pkg::LOCKOUT_PAUSE_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
    output logic [flash_host_pkg::ADDR_W-1:0] address_pins,
    output logic [flash_host_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_pins_in,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    output logic id_sense_line_elevate
);
    typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_PAUSE, S_READ} seq_t;
    seq_t state, next_state;
    flash_host_pkg::op_t op, next_op;
    logic [2:0] step, next_step;
    logic [31:0] pause, next_pause;
    logic [flash_host_pkg::ADDR_W-1:0] t_addr, next_t_addr;
    logic [flash_host_pkg::DATA_W-1:0] t_data, next_t_data;
    logic [flash_host_pkg::DATA_W-1:0] last_rd, next_last_rd, next_rsp_data;
    logic have_rd, next_have_rd, next_rsp_valid;
    logic bc_start, bc_write, bc_done;
    logic [flash_host_pkg::ADDR_W-1:0] bc_addr;
    logic [flash_host_pkg::DATA_W-1:0] bc_data, bc_rdata;

    // ----
    // Command step table
    // ----
    // Upper data byte unused, driven zero
    function automatic logic [31:0] step_word(input flash_host_pkg::op_t o, input logic [2:0] s);
        logic [7:0] d;
        logic [14:0] a;
        d = flash_host_pkg::UNLOCK_DATA1;
        a = flash_host_pkg::UNLOCK_ADDR1;
        if (s == 3'h1 || s == 3'h4)
        begin
            a = flash_host_pkg::UNLOCK_ADDR2;
            d = flash_host_pkg::UNLOCK_DATA2;
        end
        else if (s == 3'h2)
        begin
            case (o)
                flash_host_pkg::OP_PROGRAM: d = flash_host_pkg::CMD_PROGRAM; // RULE2
                flash_host_pkg::OP_ID_ENTRY: d = flash_host_pkg::CMD_ID_ENTRY; // RULE6
                flash_host_pkg::OP_ID_EXIT: d = flash_host_pkg::CMD_ID_EXIT; // RULE7
                default: d = flash_host_pkg::CMD_ERASE_SETUP;
            endcase
        end
        else if (s == 3'h5)
        begin
            case (o)
                flash_host_pkg::OP_CHIP_ERASE: d = flash_host_pkg::CMD_CHIP_ERASE; // RULE3
                flash_host_pkg::OP_MAIN_ERASE: d = flash_host_pkg::CMD_MAIN_ERASE; // RULE4
                default: d = flash_host_pkg::CMD_LOCKOUT; // RULE5
            endcase
        end
        step_word = {1'b0, a, 8'h00, d}; // RULE1
    endfunction

    function automatic logic [2:0] last_step(input flash_host_pkg::op_t o);
        case (o)
            flash_host_pkg::OP_PROGRAM: last_step = 3'h3;
            flash_host_pkg::OP_ID_ENTRY, flash_host_pkg::OP_ID_EXIT: last_step = 3'h2;
            flash_host_pkg::OP_ID_EXIT_SHORT, flash_host_pkg::OP_READ: last_step = 3'h0;
            default: last_step = 3'h5;
        endcase
    endfunction

    logic [31:0] sw;
    always_comb
    begin
        sw = step_word(op, step);
        bc_addr = sw[31:16];
        bc_data = sw[15:0];
        bc_write = 1'b1;
        if (op == flash_host_pkg::OP_READ || state == S_POLL)
        begin
            bc_addr = t_addr;
            bc_write = 1'b0;
        end
        else if (op == flash_host_pkg::OP_PROGRAM && step == 3'h3)
        begin
            bc_addr = t_addr; // RULE2
            bc_data = t_data;
        end
        else if (op == flash_host_pkg::OP_ID_EXIT_SHORT)
            bc_data = {8'h00, flash_host_pkg::CMD_ID_EXIT}; // RULE8
    end

    assign cmd_ready = (state == S_IDLE);
    assign bc_start = (state == S_ISSUE) || (state == S_POLL && !bc_done);

    // ----
    // Sequencer
    // ----
    always_comb
    begin
        next_state = state;
        next_op = op;
        next_step = step;
        next_pause = pause;
        next_t_addr = t_addr;
        next_t_data = t_data;
        next_last_rd = last_rd;
        next_have_rd = have_rd;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        case (state)
            S_IDLE:
            begin
                // Busy until previous operation ends
                if (cmd_valid) // RULE20
                begin
                    next_op = flash_host_pkg::op_t'(cmd_op);
                    next_t_addr = cmd_addr;
                    next_t_data = cmd_data;
                    next_step = 3'h0;
                    next_state = S_ISSUE;
                end
            end
            S_ISSUE:
                next_state = S_WAIT;
            S_WAIT:
            begin
                if (bc_done)
                begin
                    if (op == flash_host_pkg::OP_READ)
                    begin
                        next_rsp_data = bc_rdata;
                        next_rsp_valid = 1'b1;
                        next_state = S_IDLE;
                    end
                    else if (step != last_step(op))
                    begin
                        next_step = step + 3'h1;
                        next_state = S_ISSUE;
                    end
                    else
                    begin
                        next_have_rd = 1'b0;
                        next_pause = 32'h0000_0000;
                        case (op)
                            flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CHIP_ERASE,
                            flash_host_pkg::OP_MAIN_ERASE:
                                next_state = S_POLL;
                            flash_host_pkg::OP_LOCKOUT:
                            begin
                                next_pause = 32'(LOCKOUT_PAUSE); // RULE5
                                next_state = S_PAUSE;
                            end
                            default:
                            begin
                                next_pause = 32'(ID_PAUSE); // RULE6 RULE7
                                next_state = S_PAUSE;
                            end
                        endcase
                    end
                end
            end
            S_POLL:
            begin
                // Done when two reads agree on toggle
                if (bc_done)
                begin
                    next_last_rd = bc_rdata;
                    next_have_rd = 1'b1;
                    if (have_rd && bc_rdata[flash_host_pkg::TOGGLE_BIT] ==
                        last_rd[flash_host_pkg::TOGGLE_BIT]) // RULE17
                    begin
                        next_rsp_data = bc_rdata;
                        next_rsp_valid = 1'b1;
                        next_state = S_IDLE;
                    end
                end
            end
            S_PAUSE:
            begin
                if (pause <= 32'h0000_0001)
                begin
                    next_rsp_valid = 1'b1;
                    next_rsp_data = '0;
                    next_state = S_IDLE;
                end
                else
                    next_pause = pause - 32'h0000_0001;
            end
            default:
                next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= S_IDLE;
            op <= flash_host_pkg::OP_READ;
            step <= 3'h0;
            pause <= 32'h0000_0000;
            t_addr <= '0;
            t_data <= '0;
            last_rd <= '0;
            have_rd <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            step <= next_step;
            pause <= next_pause;
            t_addr <= next_t_addr;
            t_data <= next_t_data;
            last_rd <= next_last_rd;
            have_rd <= next_have_rd;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
        end
    end

    // Pin-level identification unused
    assign id_sense_line_elevate = 1'b0; // RULE13

    flash_bus_cycle u_cycle
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(bc_start && state != S_WAIT),
        .is_write(bc_write),
        .addr(bc_addr),
        .wdata(bc_data),
        .done(bc_done),
        .rdata(bc_rdata),
        .address_pins(address_pins),
        .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe),
        .data_pins_in(data_pins_in),
        .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n)
    );
endmodule
`default_nettype wire

// ===== tb/flash_device_model.sv
// Behavioural model of the parallel flash device seen at the host pins
`timescale 1ns/100ps
`default_nettype none
module flash_device_model
#(
    parameter logic [15:0] MAKER_CODE = 16'h0042, // Arbitrary
    parameter logic [15:0] PART_CODE = 16'h0017, // Arbitrary
    parameter int BUSY_NS = 800
)
(
    input wire logic power_on,
    input wire logic [15:0] address_pins,
    input wire logic [15:0] data_pins_out,
    input wire logic data_pins_oe,
    output logic [15:0] data_pins_in,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic id_sense_line_elevate
);
    // ----
    // Command decode and array
    // ----
    logic [15:0] mem [0:65535];
    logic [15:0] last_data = 16'hffff;
    logic [15:0] last_bus = 16'h0000;
    logic [15:0] rd;
    logic [2:0] step = 3'h0;
    logic identification_mode = 1'b0;
    logic locked = 1'b0;
    logic busy = 1'b0;
    logic tgl = 1'b0;
    event op_start;
    wire logic [7:0] d = data_pins_out[7:0];
    wire logic at1 = address_pins[14:0] == 15'h5555;
    wire logic at2 = address_pins[14:0] == 15'h2aaa;
    // A fresh unlock restarts an abandoned sequence
    wire logic [2:0] restart = (at1 && d == 8'haa) ? 3'h1 : 3'h0;
    wire logic drive = !chip_select_n && !output_gate_n;
    wire logic boot = locked && address_pins < 16'h2000;
    initial
        for (int i = 0; i < 65536; i++)
            mem[i] = 16'hffff;
    always @(posedge write_strobe_n)
    begin
        if (!chip_select_n && output_gate_n && data_pins_oe && power_on && !busy)
        begin
            case (step)
                3'h0:
                begin
                    step = restart;
                    if (d == 8'hf0) identification_mode = 1'b0;
                end
                3'h1: step = (at2 && d == 8'h55) ? 3'h2 : restart;
                3'h2:
                begin
                    step = restart;
                    if (at1 && d == 8'ha0) step = 3'h3;
                    if (at1 && d == 8'h80) step = 3'h4;
                    if (at1 && d == 8'h90) identification_mode = 1'b1;
                    if (at1 && d == 8'hf0) identification_mode = 1'b0;
                end
                3'h3:
                begin
                    step = 3'h0;
                    last_data = data_pins_out;
                    if (!boot) mem[address_pins] = mem[address_pins] & data_pins_out;
                    -> op_start;
                end
                3'h4: step = (restart != 3'h0) ? 3'h5 : 3'h0;
                3'h5: step = (at2 && d == 8'h55) ? 3'h6 : restart;
                3'h6:
                begin
                    step = restart;
                    if (at1 && d == 8'h40) locked = 1'b1;
                    if (at1 && (d == 8'h10 || d == 8'h30))
                    begin
                        last_data = 16'hffff;
                        for (int i = 0; i < 65536; i++)
                            if (i >= 16'h2000 || !(locked || d == 8'h30)) mem[i] = 16'hffff;
                        -> op_start;
                    end
                end
                default: step = restart;
            endcase
        end
    end
    always @(op_start)
    begin
        busy = 1'b1;
        #(BUSY_NS) busy = 1'b0;
    end
    always @(posedge output_gate_n)
        if (!chip_select_n && busy) tgl = ~tgl;
    always @(negedge power_on)
    begin
        identification_mode = 1'b0;
        step = 3'h0;
    end
    // ----
    // Read path
    // ----
    always_comb
    begin
        rd = mem[address_pins];
        if ((identification_mode || id_sense_line_elevate) && address_pins[15:2] == 14'h0)
        begin
            rd = address_pins[0] ? PART_CODE : MAKER_CODE;
            if (address_pins[1]) rd = locked ? 16'h00ff : 16'h00fe;
        end
        if (busy)
        begin
            rd[7] = ~last_data[7];
            rd[6] = tgl;
        end
    end
    // Released bus shows the inverse of its last level so a stale sample is caught
    assign data_pins_in = drive ? rd : (data_pins_oe ? data_pins_out : ~last_bus);
    always @(data_pins_in)
        if (drive || data_pins_oe) last_bus = data_pins_in;
endmodule
`default_nettype wire

// ===== tb/flash_command_host_asserts.sv
// Pin protocol checks for the flash host sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_command_host_asserts
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [15:0] address_pins,
    input wire logic [15:0] data_pins_out,
    input wire logic data_pins_oe,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic id_sense_line_elevate
);
    // ----
    // Strobe width counter
    // ----
    logic [7:0] low_cnt;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt <= 8'h00;
        else
            low_cnt <= write_strobe_n ? 8'h00 : low_cnt + 8'h01;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ----
    // Properties
    // ----
    property p_no_fight; data_pins_oe |-> output_gate_n; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data fight");
    property p_read_gate; !output_gate_n |-> !chip_select_n && write_strobe_n && !data_pins_oe; endproperty
    a_read_gate: assert property (p_read_gate) else $error("bad read");
    property p_write_qual; !write_strobe_n |-> !chip_select_n && output_gate_n && data_pins_oe; endproperty
    a_write_qual: assert property (p_write_qual) else $error("bad write");
    property p_strobe_width; $rose(write_strobe_n) |-> low_cnt >= flash_host_pkg::STROBE_CYCLES - 1; endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe short");
    property p_setup; $fell(write_strobe_n) |-> $past(!chip_select_n && data_pins_oe, 20); endproperty
    a_setup: assert property (p_setup) else $error("setup short");
    property p_hold; $rose(write_strobe_n) |-> (!chip_select_n && data_pins_oe) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("hold short");
    property p_stable; !write_strobe_n && $past(!write_strobe_n) |-> $stable(address_pins) && $stable(data_pins_out); endproperty
    a_stable: assert property (p_stable) else $error("bus moved");
    property p_busy; cmd_valid && cmd_ready |=> !cmd_ready [*8]; endproperty
    a_busy: assert property (p_busy) else $error("busy accept");
    property p_release; rsp_valid |-> cmd_ready ##1 !rsp_valid; endproperty
    a_release: assert property (p_release) else $error("not idle");
    property p_no_pin_id; !id_sense_line_elevate; endproperty
    a_no_pin_id: assert property (p_no_pin_id) else $error("elevated");
endmodule
bind flash_command_host flash_command_host_asserts chk
(
    .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .address_pins(address_pins), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .write_strobe_n(write_strobe_n), .id_sense_line_elevate(id_sense_line_elevate)
);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the flash host sequencer driving a device model
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed
    {
        logic [2:0] op;
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_t;
    localparam logic [15:0] MAKER = 16'h0042; // Arbitrary value
    localparam logic [15:0] PART = 16'h0017; // Arbitrary value
    localparam int NROWS = 21;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic power_on = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h7;
    logic [15:0] cmd_addr = 16'h0000;
    logic [15:0] cmd_data = 16'h0000;
    logic cmd_ready, rsp_valid, data_pins_oe, chip_select_n, output_gate_n, write_strobe_n, elev;
    logic [15:0] rsp_data, address_pins, data_pins_out, data_pins_in, got;
    int err_count = 0;
    int compares = 0;
    row_t rows [NROWS];
    flash_command_host #(.ID_PAUSE(20), .LOCKOUT_PAUSE(20)) dut
    (
        .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .address_pins(address_pins), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .id_sense_line_elevate(elev)
    );
    flash_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_NS(800)) flash
    (
        .power_on(power_on), .address_pins(address_pins), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .id_sense_line_elevate(elev)
    );
    initial forever #2 sys_clk = ~sys_clk;
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run_cmd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] res);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 20000) err_count++;
        res = rsp_data;
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang limit, well past the run
    initial
    begin
        #400000 err_count++;
        wrap_up();
    end
    // ----
    // Main sequence
    // ----
    initial
    begin
        rows = '{'{3'h7, 16'h0100, 16'h0, 16'hffff}, '{3'h0, 16'h0100, 16'h1234, 16'h1234},
            '{3'h7, 16'h0100, 16'h0, 16'h1234}, '{3'h0, 16'h3000, 16'ha5c3, 16'ha5c3},
            '{3'h0, 16'h3000, 16'hff0f, 16'ha503}, '{3'h4, 16'h0, 16'h0, 16'h0},
            '{3'h7, 16'h0000, 16'h0, MAKER}, '{3'h7, 16'h0001, 16'h0, PART},
            '{3'h7, 16'h0002, 16'h0, 16'h00fe}, '{3'h5, 16'h0, 16'h0, 16'h0},
            '{3'h7, 16'h0001, 16'h0, 16'hffff}, '{3'h3, 16'h0, 16'h0, 16'h0},
            '{3'h0, 16'h0100, 16'h0000, 16'h1234}, '{3'h4, 16'h0, 16'h0, 16'h0},
            '{3'h7, 16'h0002, 16'h0, 16'h00ff}, '{3'h6, 16'h0, 16'h0, 16'h0},
            '{3'h7, 16'h0002, 16'h0, 16'hffff}, '{3'h2, 16'h3000, 16'h0, 16'hffff},
            '{3'h7, 16'h0100, 16'h0, 16'h1234}, '{3'h1, 16'h3000, 16'h0, 16'hffff},
            '{3'h7, 16'h0100, 16'h0, 16'h1234}};
        repeat (5) @(posedge sys_clk);
        check({10'h0, chip_select_n, output_gate_n, write_strobe_n, data_pins_oe, cmd_ready,
            rsp_valid}, 16'h003a);
        #1 nrst = 1'b1;
        for (int i = 0; i < NROWS; i++)
        begin
            run_cmd(rows[i].op, rows[i].a, rows[i].d, got);
            check(got, rows[i].e);
        end
        // Power loss drops ID mode
        run_cmd(3'h4, 16'h0, 16'h0, got);
        power_on = 1'b0;
        nrst = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 power_on = 1'b1;
        nrst = 1'b1;
        run_cmd(3'h7, 16'h0000, 16'h0, got);
        check(got, 16'hffff);
        // Reset in the second write leaves a partial sequence
        cmd_op = 3'h1;
        cmd_addr = 16'h3000;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        repeat (120) @(posedge sys_clk);
        #1 nrst = 1'b0;
        #1 check({13'h0, chip_select_n, write_strobe_n, data_pins_oe}, 16'h0006);
        @(posedge sys_clk);
        #1 nrst = 1'b1;
        run_cmd(3'h0, 16'h3001, 16'h0f0f, got);
        check(got, 16'h0f0f);
        wrap_up();
    end
endmodule
`default_nettype wire
